//--- rtl/dpw_pkg.sv
// Shared constants and types of the direct pixel write unpacker
package dpw_pkg;
  // --------------------------------------------------
  // Register map
  // --------------------------------------------------
  localparam int REG_ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_COLOR = 5'h04;
  localparam logic [4:0] OFS_ZA = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [2:0] SEL_CTRL = 3'h0;
  localparam logic [2:0] SEL_COLOR = 3'h1;
  localparam logic [2:0] SEL_ZA = 3'h2;
  localparam logic [2:0] SEL_DATA = 3'h3;
  localparam logic [2:0] SEL_STAT = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h7;
  // --------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------
  localparam int FMT_LSB = 0;
  localparam int PIPE_BIT = 8;
  localparam int ORDER_LSB = 9;
  localparam int HSWAP_BIT = 11;
  localparam int BSWAP_BIT = 12;
  localparam logic [31:0] CTRL_MASK = 32'h00001f0f;
  localparam logic [31:0] COLOR_MASK = 32'h00ffffff;
  localparam int ZA_DEPTH_LSB = 0;
  localparam int ZA_ALPHA_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CNT_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] COLOR_RESET = 32'h00000000;
  localparam logic [31:0] ZA_RESET = 32'h00000000;
  // --------------------------------------------------
  // Write format codes
  // --------------------------------------------------
  localparam logic [3:0] FMT_565 = 4'h0;
  localparam logic [3:0] FMT_555 = 4'h1;
  localparam logic [3:0] FMT_1555 = 4'h2;
  localparam logic [3:0] FMT_888 = 4'h4;
  localparam logic [3:0] FMT_8888 = 4'h5;
  localparam logic [3:0] FMT_Z565 = 4'hc;
  localparam logic [3:0] FMT_Z555 = 4'hd;
  localparam logic [3:0] FMT_Z1555 = 4'he;
  localparam logic [3:0] FMT_ZZ = 4'hf;
  // --------------------------------------------------
  // Bus answers and types
  // --------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {KIND_565, KIND_555} dpw_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_EMIT0, ST_EMIT1} dpw_state_t;
endpackage : dpw_pkg

//--- rtl/dpw_word_order.sv
// Byte reversal and half swap of an incoming host word
`timescale 1ns/1ps
module dpw_word_order (
  input wire logic [31:0] rawWord,
  input wire logic byteSwap,
  input wire logic halfSwap,
  input wire logic [3:0] format,
  output logic [31:0] orderedWord
);
  logic [31:0] swizzled;
  logic wideFmt;

  // --------------------------------------------------
  // Reversal first, then half swap
  // --------------------------------------------------
  always_comb begin
    swizzled = byteSwap ? {rawWord[7:0], rawWord[15:8], rawWord[23:16], rawWord[31:24]} : rawWord;
    wideFmt = (format == dpw_pkg::FMT_888) || (format == dpw_pkg::FMT_8888);
    // exchange halves afterwards
    // Wide formats never see a half swap
    orderedWord = (halfSwap && !wideFmt) ? {swizzled[15:0], swizzled[31:16]} : swizzled;
  end
endmodule : dpw_word_order

//--- rtl/dpw_half_decode.sv
// Colour lane decode of one 16-bit pixel half
`timescale 1ns/1ps
module dpw_half_decode (
  input wire logic [15:0] half,
  input wire logic kind565,
  input wire logic [1:0] order,
  output logic [7:0] red,
  output logic [7:0] green,
  output logic [7:0] blue,
  output logic alphaBit
);
  logic [4:0] upper;
  logic [4:0] lower;
  logic [5:0] mid;

  // --------------------------------------------------
  // Field placement
  // --------------------------------------------------
  always_comb begin
    if (kind565) begin
      upper = half[15:11];
      mid = half[10:5];
      lower = half[4:0];
      alphaBit = 1'b0;
    end else if (!order[1]) begin
      upper = half[14:10];
      mid = {1'b0, half[9:5]};
      lower = half[4:0];
      alphaBit = half[15];
    end else begin
      upper = half[15:11];
      mid = {1'b0, half[10:6]};
      lower = half[5:1];
      alphaBit = half[0];
    end
    // odd orders put blue on top
    red = order[0] ? {3'h0, lower} : {3'h0, upper};
    blue = order[0] ? {3'h0, upper} : {3'h0, lower};
    green = {2'h0, mid};
  end
endmodule : dpw_half_decode

//--- rtl/dpw_unpacker.sv
// Direct frame buffer write unpacker with an AXI4-Lite register port
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// --------------------------------------------------
// How it works
// - Format 0: 5-6-5, odd orders swap
// - Formats 0,1,4 piped: constant alpha, depth
// - Format 1: 5-5-5, one bit ignored
// - Format 2: alpha bit top or bottom
// - One alpha bit replicated to eight
// - Formats 2,5 piped: constant depth
// - Format 3 is unsupported
// - Formats 6 to 11 unsupported
// - Format 4: 8-8-8 in 32-bit word
// - Format 5: 8-8-8-8, alpha top/bottom
// - Format 12: 5-6-5 plus depth half
// - Format 13: 5-5-5 plus depth half
// - Format 14: 1-5-5-5 plus depth half
// - Formats 12,13 piped: constant alpha
// - Format 15: two depths, constant colour
// - Format 4 unused byte never alpha
// - Byte reversal, half swap, then lanes
// - Depth high half unless swapped
// - Orders: ARGB, ABGR, RGBA, BGRA
// --------------------------------------------------
module dpw_unpacker #(
  parameter int ADDR_W = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pixValid,
  output logic pixRight,
  output logic pixThroughPipe,
  output logic [3:0] pixFormat,
  output logic [7:0] pixRed,
  output logic [7:0] pixGreen,
  output logic [7:0] pixBlue,
  output logic [7:0] pixAlpha,
  output logic [15:0] pixDepth,
  output logic pixColorEn,
  output logic pixAlphaEn,
  output logic pixDepthEn
);
  // --------------------------------------------------
  // Elaboration check
  // --------------------------------------------------
  if (ADDR_W < dpw_pkg::REG_ADDR_W) begin : g_bad_addr
    $error("ADDR_W too small for the register map");
  end

  // --------------------------------------------------
  // Helpers
  // --------------------------------------------------
  function automatic logic [2:0] regSel(input logic [ADDR_W-1:0] a);
    logic [2:0] sel;
    sel = dpw_pkg::SEL_NONE;
    if ((a >> dpw_pkg::REG_ADDR_W) == '0) begin
      case (a[dpw_pkg::REG_ADDR_W-1:0])
        dpw_pkg::OFS_CTRL: sel = dpw_pkg::SEL_CTRL;
        dpw_pkg::OFS_COLOR: sel = dpw_pkg::SEL_COLOR;
        dpw_pkg::OFS_ZA: sel = dpw_pkg::SEL_ZA;
        dpw_pkg::OFS_DATA: sel = dpw_pkg::SEL_DATA;
        dpw_pkg::OFS_STAT: sel = dpw_pkg::SEL_STAT;
        default: sel = dpw_pkg::SEL_NONE;
      endcase
    end
    return sel;
  endfunction : regSel

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic supported(input logic [3:0] f);
    return !(f == 4'h3 || (f >= 4'h6 && f <= 4'hb));
  endfunction : supported

  // --------------------------------------------------
  // Registers and bus state
  // --------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] color_q;
  logic [31:0] za_q;
  logic [31:0] data_q;
  logic [15:0] pixCount_q;
  logic awHeld_q;
  logic wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  dpw_pkg::dpw_state_t state_q;
  dpw_pkg::dpw_state_t state_d;
  logic commit;
  logic [2:0] wSel;
  logic [31:0] newData;
  logic [3:0] fmt;
  logic [1:0] order;
  logic pipeOn;
  logic twoPix;
  logic [31:0] word;

  assign fmt = ctrl_q[dpw_pkg::FMT_LSB +: 4];
  assign order = ctrl_q[dpw_pkg::ORDER_LSB +: 2];
  assign pipeOn = ctrl_q[dpw_pkg::PIPE_BIT];
  assign twoPix = (fmt <= dpw_pkg::FMT_1555) || (fmt == dpw_pkg::FMT_ZZ);
  assign wSel = regSel(awAddr_q);
  assign newData = merge(data_q, wData_q, wStrb_q);
  // Config cannot change under a pending pixel: writes wait for idle
  assign commit = awHeld_q && wHeld_q && !bvalid_q && (state_q == dpw_pkg::ST_IDLE);

  // --------------------------------------------------
  // Write channels
  // --------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b0;
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
    end else begin
      awready_q <= s_axi_awvalid && !awready_q && !awHeld_q;
      if (s_axi_awvalid && awready_q) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (commit) begin
        awHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wready_q <= 1'b0;
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else begin
      wready_q <= s_axi_wvalid && !wready_q && !wHeld_q;
      if (s_axi_wvalid && wready_q) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (commit) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= dpw_pkg::RESP_OKAY;
    end else if (commit) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wSel == dpw_pkg::SEL_NONE) ? dpw_pkg::RESP_SLVERR : dpw_pkg::RESP_OKAY;
    end else if (s_axi_bready && bvalid_q) begin
      bvalid_q <= 1'b0;
    end
  end

  // --------------------------------------------------
  // Register file
  // --------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= dpw_pkg::CTRL_RESET;
      color_q <= dpw_pkg::COLOR_RESET;
      za_q <= dpw_pkg::ZA_RESET;
      data_q <= '0;
    end else if (commit) begin
      case (wSel)
        dpw_pkg::SEL_CTRL: ctrl_q <= merge(ctrl_q, wData_q, wStrb_q) & dpw_pkg::CTRL_MASK;
        dpw_pkg::SEL_COLOR: color_q <= merge(color_q, wData_q, wStrb_q) & dpw_pkg::COLOR_MASK;
        dpw_pkg::SEL_ZA: za_q <= merge(za_q, wData_q, wStrb_q);
        dpw_pkg::SEL_DATA: data_q <= newData;
        default: data_q <= data_q;
      endcase
    end
  end

  // --------------------------------------------------
  // Read channel
  // --------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= dpw_pkg::RESP_OKAY;
    end else begin
      arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
      if (s_axi_arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= dpw_pkg::RESP_OKAY;
        case (regSel(s_axi_araddr))
          dpw_pkg::SEL_CTRL: rdata_q <= ctrl_q;
          dpw_pkg::SEL_COLOR: rdata_q <= color_q;
          dpw_pkg::SEL_ZA: rdata_q <= za_q;
          dpw_pkg::SEL_DATA: rdata_q <= data_q;
          dpw_pkg::SEL_STAT: begin
            rdata_q <= '0;
            rdata_q[dpw_pkg::STAT_BUSY_BIT] <= (state_q != dpw_pkg::ST_IDLE);
            rdata_q[dpw_pkg::STAT_CNT_LSB +: 16] <= pixCount_q;
          end
          default: begin
            rdata_q <= '0;
            rresp_q <= dpw_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready && rvalid_q) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------
  // Pixel sequencing
  // --------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      dpw_pkg::ST_IDLE: begin
        // unsupported data is stored but never emitted
        if (commit && wSel == dpw_pkg::SEL_DATA && supported(fmt)) begin
          state_d = dpw_pkg::ST_EMIT0;
        end
      end
      dpw_pkg::ST_EMIT0: state_d = twoPix ? dpw_pkg::ST_EMIT1 : dpw_pkg::ST_IDLE;
      dpw_pkg::ST_EMIT1: state_d = dpw_pkg::ST_IDLE;
      default: state_d = dpw_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= dpw_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixCount_q <= '0;
    end else if (state_q != dpw_pkg::ST_IDLE) begin
      pixCount_q <= pixCount_q + 16'h0001;
    end
  end

  // --------------------------------------------------
  // Decode
  // --------------------------------------------------
  logic [15:0] colHalf;
  logic [15:0] slotHalf;
  logic [7:0] hRed;
  logic [7:0] hGreen;
  logic [7:0] hBlue;
  logic hAlpha;
  logic kind565;
  logic [7:0] dRed;
  logic [7:0] dGreen;
  logic [7:0] dBlue;
  logic [7:0] dAlpha;
  logic [15:0] dDepth;
  logic dColorEn;
  logic dAlphaEn;
  logic dDepthEn;

  dpw_word_order u_order (
    .rawWord(data_q),
    .byteSwap(ctrl_q[dpw_pkg::BSWAP_BIT]),
    .halfSwap(ctrl_q[dpw_pkg::HSWAP_BIT]),
    .format(fmt),
    .orderedWord(word)
  );

  // Left pixel sits in the low half once halves are ordered
  assign slotHalf = (state_q == dpw_pkg::ST_EMIT1) ? word[31:16] : word[15:0];
  // colour in low half for depth formats
  assign colHalf = (fmt >= dpw_pkg::FMT_Z565) ? word[15:0] : slotHalf;
  assign kind565 = (fmt == dpw_pkg::FMT_565) || (fmt == dpw_pkg::FMT_Z565);

  dpw_half_decode u_half (
    .half(colHalf),
    .kind565(kind565),
    .order(order),
    .red(hRed),
    .green(hGreen),
    .blue(hBlue),
    .alphaBit(hAlpha)
  );

  always_comb begin
    dRed = hRed;
    dGreen = hGreen;
    dBlue = hBlue;
    dAlpha = za_q[dpw_pkg::ZA_ALPHA_LSB +: 8];
    dDepth = za_q[dpw_pkg::ZA_DEPTH_LSB +: 16];
    dColorEn = 1'b1;
    dAlphaEn = pipeOn;
    dDepthEn = pipeOn;
    case (fmt)
      dpw_pkg::FMT_1555, dpw_pkg::FMT_Z1555: begin
        dAlpha = {8{hAlpha}};
        dAlphaEn = 1'b1;
        dDepthEn = pipeOn || (fmt == dpw_pkg::FMT_Z1555);
        if (fmt == dpw_pkg::FMT_Z1555) begin
          dDepth = word[31:16];
        end
      end
      dpw_pkg::FMT_888, dpw_pkg::FMT_8888: begin
        if (!order[1]) begin
          dRed = order[0] ? word[7:0] : word[23:16];
          dGreen = word[15:8];
          dBlue = order[0] ? word[23:16] : word[7:0];
        end else begin
          dRed = order[0] ? word[15:8] : word[31:24];
          dGreen = word[23:16];
          dBlue = order[0] ? word[31:24] : word[15:8];
        end
        if (fmt == dpw_pkg::FMT_8888) begin
          dAlpha = order[1] ? word[7:0] : word[31:24];
          dAlphaEn = 1'b1;
        end
      end
      dpw_pkg::FMT_Z565, dpw_pkg::FMT_Z555: begin
        dDepth = word[31:16];
        dDepthEn = 1'b1;
      end
      dpw_pkg::FMT_ZZ: begin
        dRed = color_q[23:16];
        dGreen = color_q[15:8];
        dBlue = color_q[7:0];
        dDepth = slotHalf;
        dColorEn = pipeOn;
        dDepthEn = 1'b1;
      end
      default: begin
        // formats 0,1 take constant alpha and depth
        dColorEn = 1'b1;
      end
    endcase
  end

  // --------------------------------------------------
  // Pixel outputs
  // --------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixValid <= 1'b0;
      pixRight <= 1'b0;
      pixThroughPipe <= 1'b0;
      pixFormat <= '0;
      pixRed <= '0;
      pixGreen <= '0;
      pixBlue <= '0;
      pixAlpha <= '0;
      pixDepth <= '0;
      pixColorEn <= 1'b0;
      pixAlphaEn <= 1'b0;
      pixDepthEn <= 1'b0;
    end else begin
      pixValid <= (state_q != dpw_pkg::ST_IDLE);
      if (state_q != dpw_pkg::ST_IDLE) begin
        pixRight <= (state_q == dpw_pkg::ST_EMIT1);
        pixThroughPipe <= pipeOn;
        pixFormat <= fmt;
        pixRed <= dRed;
        pixGreen <= dGreen;
        pixBlue <= dBlue;
        pixAlpha <= dAlpha;
        pixDepth <= dDepth;
        pixColorEn <= dColorEn;
        pixAlphaEn <= dAlphaEn;
        pixDepthEn <= dDepthEn;
      end
    end
  end

  // --------------------------------------------------
  // Bus outputs
  // --------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule : dpw_unpacker

//--- tb/dpw_unpacker_props.sv
// Checker of the pixel outputs of the unpacker
`timescale 1ns/1ps
module dpw_unpacker_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic pixValid,
  input wire logic pixRight,
  input wire logic pixThroughPipe,
  input wire logic [3:0] pixFormat,
  input wire logic [7:0] pixRed,
  input wire logic [7:0] pixGreen,
  input wire logic [7:0] pixAlpha,
  input wire logic pixColorEn,
  input wire logic pixAlphaEn,
  input wire logic pixDepthEn
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // --------------------------------------------------
  // Pixel rules
  // --------------------------------------------------
  property p_pipe_en; pixValid && pixThroughPipe |-> pixColorEn && pixAlphaEn && pixDepthEn; endproperty
  a_pipe_en: assert property (p_pipe_en) else $error("piped pixel lacks an enable");
  property p_no_fmt3; pixValid |-> pixFormat != 4'h3; endproperty
  a_no_fmt3: assert property (p_no_fmt3) else $error("format 3 pixel emitted");
  property p_no_fmt6to11; pixValid |-> !(pixFormat inside {[4'h6:4'hb]}); endproperty
  a_no_fmt6to11: assert property (p_no_fmt6to11) else $error("unsupported format pixel emitted");
  property p_565_width; pixValid && pixFormat == 4'h0 |-> pixRed[7:5] == 3'h0 && pixGreen[7:6] == 2'h0; endproperty
  a_565_width: assert property (p_565_width) else $error("565 field too wide");
  property p_555_width; pixValid && pixFormat == 4'h1 |-> pixRed[7:5] == 3'h0 && pixGreen[7:5] == 3'h0; endproperty
  a_555_width: assert property (p_555_width) else $error("555 field too wide");
  property p_alpha_rep; pixValid && pixFormat inside {4'h2, 4'he} |-> pixAlpha inside {8'h00, 8'hff}; endproperty
  a_alpha_rep: assert property (p_alpha_rep) else $error("alpha bit not replicated");
  property p_888_noalpha; pixValid && pixFormat == 4'h4 && !pixThroughPipe |-> !pixAlphaEn && pixColorEn; endproperty
  a_888_noalpha: assert property (p_888_noalpha) else $error("888 spare byte used as alpha");
  property p_zz_nocolor; pixValid && pixFormat == 4'hf && !pixThroughPipe |-> !pixColorEn && pixDepthEn; endproperty
  a_zz_nocolor: assert property (p_zz_nocolor) else $error("depth pair pixel enables colour");
  property p_depth_half; pixValid && pixFormat inside {4'hc, 4'hd, 4'he} |-> pixDepthEn && pixColorEn; endproperty
  a_depth_half: assert property (p_depth_half) else $error("depth half not enabled");
  property p_pair; pixValid && !pixRight && pixFormat inside {4'h0, 4'h1, 4'h2, 4'hf} |=> pixValid && pixRight;
  endproperty
  a_pair: assert property (p_pair) else $error("second pixel of pair missing");
endmodule : dpw_unpacker_props

bind dpw_unpacker dpw_unpacker_props i_dpw_unpacker_props (.clock, .rst, .pixValid, .pixRight, .pixThroughPipe,
  .pixFormat, .pixRed, .pixGreen, .pixAlpha, .pixColorEn, .pixAlphaEn, .pixDepthEn);

//--- tb/dpw_host.sv
// Host processor model issuing register writes and reads
`timescale 1ns/1ps
module dpw_host (
  input wire logic clock,
  output logic [4:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [4:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
  end
  task automatic write(input logic [4:0] addr, input logic [31:0] data, output logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      // Released lines show garbage
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~addr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~data;
      end
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : write
  task automatic read(input logic [4:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~addr;
      end
    end while (s_axi_rvalid !== 1'b1);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : read
endmodule : dpw_host

//--- tb/dpw_unpacker_bench.sv
// Self-checking bench of the direct pixel write unpacker
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin failCount++; \
  $display("[ERR] %0t got %h exp %h", $time, act, exp); end end
module dpw_unpacker_bench;
  typedef struct packed {logic rt; logic [3:0] f; logic [7:0] r, g, b, a; logic [15:0] d; logic [3:0] en;} dpw_pix_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, pixFormat;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic pixValid, pixRight, pixThroughPipe, pixColorEn, pixAlphaEn, pixDepthEn;
  logic [7:0] pixRed, pixGreen, pixBlue, pixAlpha;
  logic [15:0] pixDepth;
  logic [31:0] zaVal = 32'hc35a7e91;
  logic [31:0] colVal = 32'h00345678;
  logic [31:0] rd;
  logic [1:0] resp;
  dpw_pix_t seen[$];
  int failCount = 0, comparisons = 0;
  always #10 clock = ~clock;
  dpw_unpacker #(.ADDR_W(5)) i_dpw_unpacker (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pixValid, .pixRight, .pixThroughPipe, .pixFormat, .pixRed, .pixGreen, .pixBlue, .pixAlpha, .pixDepth,
    .pixColorEn, .pixAlphaEn, .pixDepthEn);
  dpw_host i_dpw_host (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always @(posedge clock) if (pixValid === 1'b1) seen.push_back({pixRight, pixFormat, pixRed, pixGreen, pixBlue,
    pixAlpha, pixDepth, pixThroughPipe, pixColorEn, pixAlphaEn, pixDepthEn});
  // --------------------------------------------------
  // Reference decode
  // --------------------------------------------------
  function automatic dpw_pix_t refPix(logic [31:0] c, logic [31:0] w, logic rt);
    dpw_pix_t p;
    logic [3:0] f;
    logic [15:0] h;
    logic [7:0] t;
    f = c[3:0];
    if (c[12]) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
    if (c[11] && f != 4'h4 && f != 4'h5) w = {w[15:0], w[31:16]};
    h = rt ? w[31:16] : w[15:0];
    {p.rt, p.f} = {rt, f};
    p.a = zaVal[31:24];
    p.d = (f == 4'hf) ? h : ((f >= 4'hc) ? w[31:16] : zaVal[15:0]);
    if (f == 4'h4 || f == 4'h5) begin
      {p.a, p.r, p.g, p.b} = c[10] ? {w[7:0], w[31:8]} : w;
      if (f == 4'h4) p.a = zaVal[31:24];
    end else if (f == 4'h0 || f == 4'hc) begin
      {p.r, p.g, p.b} = {3'h0, h[15:11], 2'h0, h[10:5], 3'h0, h[4:0]};
    end else begin
      {t, p.r, p.g, p.b} = c[10] ? {{8{h[0]}}, 3'h0, h[15:11], 3'h0, h[10:6], 3'h0, h[5:1]}
                                 : {{8{h[15]}}, 3'h0, h[14:10], 3'h0, h[9:5], 3'h0, h[4:0]};
      if (f == 4'h2 || f == 4'he) p.a = t;
    end
    if (c[9]) {p.r, p.b} = {p.b, p.r};
    if (f == 4'hf) {p.r, p.g, p.b} = colVal[23:0];
    p.en = c[8] ? 4'hf : {1'b0, f != 4'hf, f == 4'h2 || f == 4'h5 || f == 4'he, f >= 4'hc};
    return p;
  endfunction : refPix
  task automatic pixCheck(dpw_pix_t g, dpw_pix_t e);
    `CHK({g.rt, g.f}, {e.rt, e.f})
    `CHK(g.en, e.en)
    if (e.en[2]) `CHK({g.r, g.g, g.b}, {e.r, e.g, e.b})
    if (e.en[1]) `CHK(g.a, e.a)
    if (e.en[0]) `CHK(g.d, e.d)
  endtask : pixCheck
  // One control word, one data word, all pixels judged
  task automatic runWord(logic [31:0] c, logic [31:0] w);
    int n;
    i_dpw_host.write(dpw_pkg::OFS_CTRL, c, resp);
    seen.delete();
    i_dpw_host.write(dpw_pkg::OFS_DATA, w, resp);
    `CHK(resp, dpw_pkg::RESP_OKAY)
    repeat (4) @(posedge clock);
    n = (c[3:0] inside {4'h0, 4'h1, 4'h2, 4'hf}) ? 2 : ((c[3:0] inside {4'h4, 4'h5, [4'hc:4'he]}) ? 1 : 0);
    `CHK(seen.size(), n)
    for (int i = 0; i < n && i < seen.size(); i++) pixCheck(seen[i], refPix(c, w, i[0]));
  endtask : runWord
  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic tRegs();
    i_dpw_host.read(dpw_pkg::OFS_CTRL, rd, resp);
    `CHK(rd, dpw_pkg::CTRL_RESET)
    i_dpw_host.write(dpw_pkg::OFS_CTRL, 32'hffffffff, resp);
    i_dpw_host.read(dpw_pkg::OFS_CTRL, rd, resp);
    `CHK(rd, dpw_pkg::CTRL_MASK)
    i_dpw_host.write(dpw_pkg::OFS_COLOR, 32'h12345678, resp);
    i_dpw_host.read(dpw_pkg::OFS_COLOR, rd, resp);
    `CHK(rd, colVal)
    i_dpw_host.write(dpw_pkg::OFS_ZA, zaVal, resp);
    i_dpw_host.write(5'h14, 32'h0000abcd, resp);
    `CHK(resp, dpw_pkg::RESP_SLVERR)
    i_dpw_host.read(5'h14, rd, resp);
    `CHK({rd, resp}, {32'h0, dpw_pkg::RESP_SLVERR})
  endtask : tRegs
  // Packed 16-bit pairs, pipeline on for odd orders
  task automatic tFmt16();
    for (int f = 0; f < 3; f++)
      for (int o = 0; o < 4; o++) runWord({19'h0, 2'b00, o[1:0], o[0], 4'h0, f[3:0]}, 32'h9bcd6e35);
  endtask : tFmt16
  // Half swap must be ignored for 32-bit colour
  task automatic tFmt32();
    for (int f = 4; f < 6; f++)
      for (int o = 0; o < 4; o++) runWord({19'h0, 2'b01, o[1:0], o[1], 4'h0, f[3:0]}, 32'h8a4c2e71);
  endtask : tFmt32
  // raw depth values sent as the buffer expects
  task automatic tDepth();
    for (int f = 12; f < 16; f++)
      for (int k = 0; k < 4; k++) runWord({19'h0, k[1:0], k[1:0], k[0] ^ k[1], 4'h0, f[3:0]}, 32'h5a3cf00d);
  endtask : tDepth
  task automatic tUnsup();
    logic [31:0] stat0;
    for (int i = 0; i < 7; i++) begin
      i_dpw_host.read(dpw_pkg::OFS_STAT, stat0, resp);
      runWord({19'h0, 2'b00, 2'h1, 1'b1, 4'h0, 4'(i ? i + 5 : 3)}, 32'hffff0000);
      i_dpw_host.read(dpw_pkg::OFS_STAT, rd, resp);
      `CHK(rd[31:16], stat0[31:16])
    end
  endtask : tUnsup
  task automatic conclude();
    if (failCount == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    tRegs();
    tFmt16();
    tFmt32();
    tDepth();
    tUnsup();
    conclude();
  end
  // Whole run takes under 3000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    failCount++;
    conclude();
  end
endmodule : dpw_unpacker_bench
